// File: hdl/sync_serial_port.sv
/*
 * Synchronous serial port in serial peripheral interface mode:
 * master with four shift rates or slave on an external shift clock,
 * optional slave select, buffer, control, status and flag registers.
 * Assumes all pin inputs are already synchronous to clk, clk is the
 * oscillator clock, and the pad logic resolves the output enables.
 */
// Implementation choices: the placing of the registers and the strobed register port.
// Summary of operation
// - Master may start a transfer any time
// - Master starts shifting when buffer written
// - Output pin as input still receives bytes
// - Master rate: clk/4, /16, /64, timer/2
// - Bytes shift most significant bit first
// - Polarity bit sets shift clock idle level
// - Phase set: output valid before first edge
// - Sample bit picks input sample point
// - Polarity/phase bits map to standard modes
// - Slave shifts on external edges, flags done
// - Slave runs in sleep, wakes on byte
// - Mode 0100 alone enables slave select
// - Select low: transfer enabled, output driven
// - Select high: output floats at once
// - Port reset clears bit counter
// - Output pin as input blocks transmission
// - Master freezes during sleep, then resumes
// - Device reset disables port, aborts transfer
// - Busy buffer write dropped, collision bit set
// - Done byte fills buffer unless full and unread; read clears full
`timescale 1ns/1ps

module sync_serial_port (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [1:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdData,
	input  wire logic       sleepMode,
	input  wire logic       periodicTimerTick,
	input  wire logic       sckIn,
	output logic            sckOut,
	output logic            sckOe_n,
	input  wire logic       sdi,
	output logic            sdoOut,
	output logic            sdoOe_n,
	input  wire logic       slaveSel_n,
	output logic            irqReq,
	output logic            wakeReq
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0]                ctlReg;
	logic                      samplePtReg;
	logic                      ckeReg;
	logic                      fullReg;
	logic                      doneFlagReg;
	logic                      irqEnReg;
	logic                      sdoInReg;
	logic [7:0]                bufReg;
	logic [7:0]                shiftReg;
	logic                      sdoReg;
	logic                      sckReg;
	logic                      sckPrevReg;
	logic [2:0]                bitCntReg;
	logic [4:0]                edgeCntReg;
	logic [5:0]                divCntReg;
	spi_port_pkg::xfer_state_t stateReg;

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic       portOn;
	logic       idleLvl;
	logic       lastTick;
	logic [3:0] mode;
	logic       isMaster;
	logic       isSlave;
	logic       ssHold;
	logic       portClr;
	logic       wrBuf;
	logic       wrCtl;
	logic       wrSts;
	logic       wrFlg;
	logic       rdBuf;
	logic       busy;
	logic       collide;
	logic       load;
	logic       tick;
	logic       mCap;
	logic       mLch;
	logic       sLead;
	logic       sTrail;
	logic       capEv;
	logic       lchEv;
	logic       done;

	// Half bit period minus one for the oscillator divided rates
	function automatic logic [5:0] halfLimit(input logic [3:0] m);
		logic [5:0] lim;
		lim = spi_port_pkg::HALF_FAST;
		unique case (m)
			spi_port_pkg::MODE_DIV16: lim = spi_port_pkg::HALF_MID;
			spi_port_pkg::MODE_DIV64: lim = spi_port_pkg::HALF_SLOW;
			default:                  lim = spi_port_pkg::HALF_FAST;
		endcase
		return lim;
	endfunction

	// Control fields and slave select gating
	assign portOn   = ctlReg[spi_port_pkg::CTL_EN];
	assign idleLvl  = ctlReg[spi_port_pkg::CTL_IDLE];
	assign mode     = ctlReg[3:0];
	assign isMaster = mode <= spi_port_pkg::MODE_TIMER;
	assign isSlave  = (mode == spi_port_pkg::MODE_SLAVE_SS) ||
	                  (mode == spi_port_pkg::MODE_SLAVE);
	assign ssHold   = (mode == spi_port_pkg::MODE_SLAVE_SS) &&
	                  slaveSel_n;
	assign portClr  = !portOn || ssHold;

	// Register strobes
	assign wrBuf = regWr && (regAddr == spi_port_pkg::ADDR_BUFFER);
	assign wrCtl = regWr && (regAddr == spi_port_pkg::ADDR_CONTROL);
	assign wrSts = regWr && (regAddr == spi_port_pkg::ADDR_STATUS);
	assign wrFlg = regWr && (regAddr == spi_port_pkg::ADDR_FLAGS);
	assign rdBuf = regRd && (regAddr == spi_port_pkg::ADDR_BUFFER);

	// A slave is busy once its first bit has arrived
	assign busy    = isMaster ? (stateReg == spi_port_pkg::XFER_RUN)
	                          : (bitCntReg != '0);
	assign collide = wrBuf && portOn && busy;
	assign load    = wrBuf && !collide;

	// Master half-bit tick; sleep stops it so the byte freezes
	assign tick = (stateReg == spi_port_pkg::XFER_RUN) && !sleepMode &&
	              ((mode == spi_port_pkg::MODE_TIMER) ? periodicTimerTick
	              : (divCntReg == halfLimit(mode)));

	// Run ends on the last half bit so the final clock level lasts in full
	assign lastTick = tick && ((edgeCntReg == spi_port_pkg::EDGE_COUNT) ||
	                  ((edgeCntReg == spi_port_pkg::EDGE_COUNT - 5'h01) &&
	                   !(samplePtReg && !ckeReg)));

	// Master edge roles: phase picks launch, sample bit delays capture
	always_comb begin
		mCap = 1'b0;
		mLch = 1'b0;
		if (tick) begin
			if (samplePtReg) begin
				mCap = ckeReg ? edgeCntReg[0]
				              : (!edgeCntReg[0] && edgeCntReg != '0);
			end else begin
				mCap = ckeReg ? !edgeCntReg[0] : edgeCntReg[0];
			end
			mLch = (edgeCntReg < spi_port_pkg::EDGE_COUNT) &&
			       (ckeReg ? edgeCntReg[0] : !edgeCntReg[0]);
		end
	end

	// Slave edges are leading when they leave the idle level
	assign sLead  = (sckIn != sckPrevReg) && (sckPrevReg == idleLvl);
	assign sTrail = (sckIn != sckPrevReg) && (sckPrevReg != idleLvl);

	// Slave keeps shifting in sleep: nothing here looks at sleepMode
	always_comb begin
		capEv = 1'b0;
		lchEv = 1'b0;
		if (portOn && !portClr) begin
			if (isMaster) begin
				capEv = mCap;
				lchEv = mLch;
			end else if (isSlave) begin
				capEv = ckeReg ? sLead : sTrail;
				lchEv = ckeReg ? sTrail : sLead;
			end
		end
	end

	assign done = capEv && (bitCntReg == spi_port_pkg::BIT_LAST);

	// ****************************************************************
	// Master sequencing
	// ****************************************************************

	// Transfer state; enable clear or device reset aborts it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateReg <= spi_port_pkg::XFER_IDLE;
		end else if (portClr || !isMaster || lastTick) begin
			stateReg <= spi_port_pkg::XFER_IDLE;
		end else if (load) begin
			stateReg <= spi_port_pkg::XFER_RUN;
		end
	end

	// Divider and edge count, both hold still while asleep
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divCntReg  <= '0;
			edgeCntReg <= '0;
		end else if (load) begin
			divCntReg  <= '0;
			edgeCntReg <= '0;
		end else if (tick) begin
			divCntReg  <= '0;
			edgeCntReg <= edgeCntReg + 5'h01;
		end else if (stateReg == spi_port_pkg::XFER_RUN && !sleepMode) begin
			divCntReg <= divCntReg + 6'h01;
		end
	end

	// Shift clock rests at the polarity level between bytes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sckReg <= 1'b0;
		end else if (stateReg != spi_port_pkg::XFER_RUN) begin
			sckReg <= idleLvl;
		end else if (tick && edgeCntReg < spi_port_pkg::EDGE_COUNT) begin
			sckReg <= ~sckReg;
		end
	end

	// Previous external clock level for slave edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sckPrevReg <= 1'b0;
		end else begin
			sckPrevReg <= sckIn;
		end
	end

	// ****************************************************************
	// Shift path
	// ****************************************************************

	// Bit counter; forced to zero whenever the port is held in reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bitCntReg <= '0;
		end else if (portClr || load) begin
			bitCntReg <= '0;
		end else if (capEv) begin
			bitCntReg <= bitCntReg + 3'h1;
		end
	end

	// Captures enter at the bottom so the first bit ends up on top
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shiftReg <= '0;
		end else if (load) begin
			shiftReg <= regWrData;
		end else if (capEv) begin
			shiftReg <= {shiftReg[6:0], sdi};
		end
	end

	// Output bit; a capture on the same edge exposes the next bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdoReg <= 1'b0;
		end else if (load) begin
			sdoReg <= regWrData[7];
		end else if (lchEv && !done) begin
			sdoReg <= capEv ? shiftReg[6] : shiftReg[7];
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************

	// Control; collision and overflow are set by hardware and win
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctlReg <= spi_port_pkg::CONTROL_RST;
		end else begin
			if (wrCtl) begin
				ctlReg <= regWrData;
			end
			if (collide) begin
				ctlReg[spi_port_pkg::CTL_COLLIDE] <= 1'b1;
			end
			if (done && fullReg && !rdBuf) begin
				ctlReg[spi_port_pkg::CTL_OVF] <= 1'b1;
			end
		end
	end

	// Status configuration bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			samplePtReg <= 1'b0;
			ckeReg      <= 1'b0;
		end else if (wrSts) begin
			samplePtReg <= regWrData[spi_port_pkg::STS_SAMPLE];
			ckeReg <= regWrData[spi_port_pkg::STS_CKE];
		end
	end

	// Buffer: written data, then the received byte unless unread
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bufReg <= spi_port_pkg::BUFFER_RST;
		end else if (done && (!fullReg || rdBuf)) begin
			bufReg <= {shiftReg[6:0], sdi};
		end else if (load) begin
			bufReg <= regWrData;
		end
	end

	// Buffer full: set on completion, a read clears, set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fullReg <= 1'b0;
		end else if (done) begin
			fullReg <= 1'b1;
		end else if (rdBuf) begin
			fullReg <= 1'b0;
		end
	end

	// Done flag, interrupt enable and output pin direction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			doneFlagReg <= 1'b0;
			irqEnReg    <= 1'b0;
			sdoInReg    <= 1'b0;
		end else begin
			if (wrFlg) begin
				doneFlagReg <= regWrData[spi_port_pkg::FLG_DONE];
				irqEnReg    <= regWrData[spi_port_pkg::FLG_IRQEN];
				sdoInReg    <= regWrData[spi_port_pkg::FLG_SDOIN];
			end
			if (done) begin
				doneFlagReg <= 1'b1;
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdData <= '0;
		end else if (regRd) begin
			unique case (regAddr)
				spi_port_pkg::ADDR_BUFFER:  regRdData <= bufReg;
				spi_port_pkg::ADDR_CONTROL: regRdData <= ctlReg;
				spi_port_pkg::ADDR_STATUS:
					regRdData <= {samplePtReg, ckeReg, 5'h00, fullReg};
				spi_port_pkg::ADDR_FLAGS:
					regRdData <= {5'h00, sdoInReg, irqEnReg, doneFlagReg};
			endcase
		end else begin
			regRdData <= '0;
		end
	end

	// ****************************************************************
	// Pins and requests
	// ****************************************************************

	// Output enables are low while driving; select high floats at once
	assign sckOut  = sckReg;
	assign sckOe_n = !(portOn && isMaster);
	assign sdoOut  = sdoReg;
	assign sdoOe_n = !(portOn && !sdoInReg && (isMaster ||
	                 (isSlave && !ssHold)));
	assign irqReq  = doneFlagReg && irqEnReg;
	assign wakeReq = irqReq && sleepMode;

	// ****************************************************************
	// Checks
	// ****************************************************************

	a_select_float: assert property (@(posedge clk) disable iff (rst)
		(mode == spi_port_pkg::MODE_SLAVE_SS && slaveSel_n) |-> sdoOe_n)
		else $error("output driven while select high");

	a_select_drive: assert property (@(posedge clk) disable iff (rst)
		(portOn && mode == spi_port_pkg::MODE_SLAVE_SS && !slaveSel_n &&
		 !sdoInReg) |-> !sdoOe_n)
		else $error("output not driven while selected");

	a_clear_count: assert property (@(posedge clk) disable iff (rst)
		(!portOn && !wrCtl) |=> (bitCntReg == '0))
		else $error("bit counter not cleared in port reset");

	a_write_start: assert property (@(posedge clk) disable iff (rst)
		(load && portOn && isMaster && !wrCtl) |=>
		(stateReg == spi_port_pkg::XFER_RUN) ##1 !sckOe_n)
		else $error("master write did not start transfer");

	a_idle_level: assert property (@(posedge clk) disable iff (rst)
		(stateReg == spi_port_pkg::XFER_IDLE && !wrCtl) [*2] |->
		(sckOut == idleLvl))
		else $error("idle clock not at polarity level");

	a_sleep_hold: assert property (@(posedge clk) disable iff (rst)
		(isMaster && sleepMode && !regWr && !$past(regWr)) |=>
		($stable(shiftReg) && $stable(sckOut) && $stable(bitCntReg)))
		else $error("master moved while asleep");

	a_early_data: assert property (@(posedge clk) disable iff (rst)
		(load && ckeReg) |=> (sdoOut == $past(regWrData[7])))
		else $error("first bit not presented before edge");

	a_byte_flag: assert property (@(posedge clk) disable iff (rst)
		done |=> (doneFlagReg && fullReg))
		else $error("completion did not raise flags");

	a_collide_bit: assert property (@(posedge clk) disable iff (rst)
		(collide && !wrCtl) |=> (ctlReg[spi_port_pkg::CTL_COLLIDE] &&
		 $stable(bufReg)))
		else $error("collision not recorded or write not dropped");

	a_read_clear: assert property (@(posedge clk) disable iff (rst)
		(rdBuf && !done) |=> !fullReg)
		else $error("buffer read left full bit set");

	a_msb_first: assert property (@(posedge clk) disable iff (rst)
		(capEv && !load) |=> (shiftReg[0] == $past(sdi)))
		else $error("captured bit not at bottom of shifter");

	a_irq_raise: assert property (@(posedge clk) disable iff (rst)
		(done && irqEnReg && !wrFlg) |=> irqReq)
		else $error("interrupt request missing after byte");

endmodule

// File: shared/spi_port_pkg.sv
/*
 * Constants shared by the synchronous serial port: register offsets,
 * field positions, reset values, mode codes, divider and edge counts.
 * Assumes a two-bit word address on the register port and that clk is
 * the oscillator clock from which the master shift rates derive.
 */
package spi_port_pkg;

	// ****************************************************************
	// Register map (own choice of word offsets)
	// ****************************************************************
	localparam logic [1:0] ADDR_BUFFER  = 2'h0;
	localparam logic [1:0] ADDR_CONTROL = 2'h1;
	localparam logic [1:0] ADDR_STATUS  = 2'h2;
	localparam logic [1:0] ADDR_FLAGS   = 2'h3;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTL_COLLIDE = 7;
	localparam int CTL_OVF     = 6;
	localparam int CTL_EN      = 5;
	localparam int CTL_IDLE    = 4;
	localparam int STS_SAMPLE  = 7;
	localparam int STS_CKE     = 6;
	localparam int STS_FULL    = 0;
	localparam int FLG_DONE  = 0;
	localparam int FLG_IRQEN = 1;
	localparam int FLG_SDOIN = 2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] BUFFER_RST  = 8'h00;

	// ****************************************************************
	// Mode field codes
	// ****************************************************************
	localparam logic [3:0] MODE_DIV4     = 4'h0;
	localparam logic [3:0] MODE_DIV16    = 4'h1;
	localparam logic [3:0] MODE_DIV64    = 4'h2;
	localparam logic [3:0] MODE_TIMER    = 4'h3;
	localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
	localparam logic [3:0] MODE_SLAVE    = 4'h5;

	// ****************************************************************
	// Shift rates and byte framing
	// ****************************************************************
	localparam int DIV_FAST = 4;
	localparam int DIV_MID  = 16;
	localparam int DIV_SLOW = 64;
	localparam logic [5:0] HALF_FAST = 6'(DIV_FAST / 2 - 1);
	localparam logic [5:0] HALF_MID  = 6'(DIV_MID / 2 - 1);
	localparam logic [5:0] HALF_SLOW = 6'(DIV_SLOW / 2 - 1);
	localparam logic [4:0] EDGE_COUNT = 5'h10;
	localparam logic [2:0] BIT_LAST   = 3'h7;

	typedef enum logic [0:0] {
		XFER_IDLE = 1'b0,
		XFER_RUN  = 1'b1
	} xfer_state_t;

endpackage

// File: verif/spi_far_device.sv
/*
 * Far-side model of the serial link: answers as a slave when the port
 * masters the link, and drives clock, select and data as a master when
 * the port is a slave. Assumes the bench resolves the shared clock wire
 * and calls the tasks just after a rising clk edge.
 */
`timescale 1ns/1ps

module spi_far_device (
	input  wire logic clk,
	input  wire logic sck,
	input  wire logic sdoOut,
	input  wire logic idleLvl,
	output logic      sdi,
	output logic      sckIn,
	output logic      slaveSel_n
);
	logic [7:0] txByte;
	logic [7:0] rxByte;
	logic [3:0] bitIdx;
	logic       active;
	logic       sckSeen;

	initial begin
		sdi = 1'b0;
		sckIn = 1'b0;
		slaveSel_n = 1'b1;
		active = 1'b0;
		bitIdx = 4'h0;
	end

	// ****************************************************************
	// Slave role
	// ****************************************************************
	// Arm one byte; first bit is on the line before the first edge
	task automatic armSlave(input logic [7:0] b);
		txByte <= b;
		sdi <= b[7];
		bitIdx <= 4'h0;
		active <= 1'b1;
	endtask

	// Edges seen a cycle late, so data moves well clear of capture
	always @(posedge clk) begin
		sckSeen <= sck;
		if (active && sck !== sckSeen) begin
			if (sck !== idleLvl) begin
				rxByte <= {rxByte[6:0], sdoOut};
				bitIdx <= bitIdx + 4'h1;
			end else if (bitIdx == 4'h8) begin
				active <= 1'b0;
				sdi <= ~sdi; // Released line shows no stale bit
			end else
				sdi <= txByte[4'h7 - bitIdx];
		end
	end

	// ****************************************************************
	// Master role
	// ****************************************************************
	// Leading edge captures, trailing edge shifts; stopAt < 8 aborts
	task automatic driveByte(input logic [7:0] b, input int half,
		input int stopAt);
		slaveSel_n <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i == stopAt) begin
				slaveSel_n <= 1'b1;
				sdi <= ~sdi;
				return;
			end
			sdi <= b[7 - i];
			repeat (half) @(posedge clk);
			sckIn <= ~idleLvl;
			rxByte <= {rxByte[6:0], sdoOut};
			repeat (half) @(posedge clk);
			sckIn <= idleLvl;
		end
		repeat (half) @(posedge clk);
		sdi <= ~sdi;
	endtask
endmodule

// File: verif/spi_master_slave_port_tb.sv
/*
 * Self-checking bench for the serial port: register reads are noted in
 * a queue and compared when the data stands. Assumes the far-side
 * model and a single 25 MHz clock.
 */
`timescale 1ns/1ps

`define CHECK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("CHECK FAILED %0t got %0h want %0h", $time, got, exp); \
	end \
end

module spi_master_slave_port_tb;
	logic       clk;
	logic       rst;
	logic [1:0] regAddr;
	logic [7:0] regWrData;
	logic       regWr;
	logic       regRd;
	logic [7:0] regRdData;
	logic       sleepMode;
	logic       periodicTimerTick;
	logic       farSck;
	logic       sckWire;
	logic       sckOut;
	logic       sckOe_n;
	logic       sdi;
	logic       sdoOut;
	logic       sdoOe_n;
	logic       slaveSel_n;
	logic       irqReq;
	logic       wakeReq;
	logic       idleDrv;
	logic       tickOn;
	logic       rdSeen;
	logic       sckPrev;
	logic [7:0] expQ[$];
	int         mismatches;
	int         checks_done;
	int         cycles;
	int         sinceEdge;
	int         halfLen;
	int         seed;
	logic [7:0] tx;
	logic [7:0] rx;

	// ****************************************************************
	// Clock, wires, design and far side
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Shared clock wire: the port drives it only as master
	assign sckWire = sckOe_n ? farSck : sckOut;

	sync_serial_port dut (
		.clk               (clk),
		.rst               (rst),
		.regAddr           (regAddr),
		.regWrData         (regWrData),
		.regWr             (regWr),
		.regRd             (regRd),
		.regRdData         (regRdData),
		.sleepMode         (sleepMode),
		.periodicTimerTick (periodicTimerTick),
		.sckIn             (sckWire),
		.sckOut            (sckOut),
		.sckOe_n           (sckOe_n),
		.sdi               (sdi),
		.sdoOut            (sdoOut),
		.sdoOe_n           (sdoOe_n),
		.slaveSel_n        (slaveSel_n),
		.irqReq            (irqReq),
		.wakeReq           (wakeReq)
	);

	spi_far_device far (
		.clk        (clk),
		.sck        (sckWire),
		.sdoOut     (sdoOut),
		.idleLvl    (idleDrv),
		.sdi        (sdi),
		.sckIn      (farSck),
		.slaveSel_n (slaveSel_n)
	);

	// ****************************************************************
	// Monitors
	// ****************************************************************
	// Read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		rdSeen <= regRd;
		if (rdSeen)
			`CHECK(regRdData, expQ.pop_front())
	end

	// Timer ticks, shift clock half-period and the hang limit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		periodicTimerTick <= tickOn && (cycles % 3 == 0);
		sckPrev <= sckOut;
		if (sckOut !== sckPrev) begin
			halfLen <= sinceEdge;
			sinceEdge <= 1;
		end else
			sinceEdge <= sinceEdge + 1;
		if (cycles == 60000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic regRead(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		expQ.push_back(e);
		@(posedge clk);
		regRd <= 1'b0;
	endtask

	task automatic waitIrq(input int limit);
		int n;
		n = 0;
		while (irqReq !== 1'b1 && n < limit) begin
			@(posedge clk);
			n++;
		end
		#1;
		`CHECK(irqReq, 1'b1)
	endtask

	// One master byte; twist 1 collides, twist 2 sleeps mid-byte
	task automatic masterXfer(input logic [3:0] mode, input logic idle,
		input logic [7:0] flg, input int twist);
		logic held;
		int   expHalf;
		tx = $random(seed);
		rx = $random(seed);
		case (mode)
			spi_port_pkg::MODE_DIV4:  expHalf = spi_port_pkg::DIV_FAST / 2;
			spi_port_pkg::MODE_DIV16: expHalf = spi_port_pkg::DIV_MID / 2;
			spi_port_pkg::MODE_DIV64: expHalf = spi_port_pkg::DIV_SLOW / 2;
			default:                  expHalf = 3;
		endcase
		idleDrv <= idle;
		tickOn <= (mode == spi_port_pkg::MODE_TIMER);
		regWrite(spi_port_pkg::ADDR_STATUS, 8'h40);
		regWrite(spi_port_pkg::ADDR_FLAGS, flg);
		regWrite(spi_port_pkg::ADDR_CONTROL, {3'b001, idle, mode});
		@(posedge clk);
		#1;
		`CHECK(sckOut, idle)
		`CHECK(sckOe_n, 1'b0)
		far.armSlave(rx);
		regWrite(spi_port_pkg::ADDR_BUFFER, tx);
		if (twist == 1) begin
			repeat (20) @(posedge clk);
			regWrite(spi_port_pkg::ADDR_BUFFER, ~tx);
			regRead(spi_port_pkg::ADDR_CONTROL, {3'b101, idle, mode});
		end
		if (twist == 2) begin
			repeat (9) @(posedge clk);
			sleepMode <= 1'b1;
			@(posedge clk);
			#1;
			held = sckOut;
			repeat (40) @(posedge clk);
			#1;
			`CHECK(sckOut, held)
			`CHECK(irqReq, 1'b0)
			sleepMode <= 1'b0;
		end
		#1;
		if (flg[2])
			`CHECK(sdoOe_n, 1'b1)
		waitIrq(2000);
		`CHECK(halfLen, expHalf)
		if (!flg[2])
			`CHECK(far.rxByte, tx)
		regRead(spi_port_pkg::ADDR_STATUS, 8'h41);
		regRead(spi_port_pkg::ADDR_BUFFER, rx);
		regRead(spi_port_pkg::ADDR_STATUS, 8'h40);
		regWrite(spi_port_pkg::ADDR_FLAGS, 8'h00);
		regWrite(spi_port_pkg::ADDR_CONTROL, 8'h00);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seed = 32'h7c29;
		mismatches = 0;
		checks_done = 0;
		cycles = 0;
		sinceEdge = 0;
		halfLen = 0;
		rst = 1'b1;
		regAddr = 2'h0;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		sleepMode = 1'b0;
		periodicTimerTick = 1'b0;
		idleDrv = 1'b0;
		tickOn = 1'b0;
		rdSeen = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		regRead(spi_port_pkg::ADDR_CONTROL, spi_port_pkg::CONTROL_RST);
		regRead(spi_port_pkg::ADDR_STATUS, 8'h00);
		regRead(spi_port_pkg::ADDR_FLAGS, 8'h00);
		regRead(spi_port_pkg::ADDR_BUFFER, spi_port_pkg::BUFFER_RST);
		// Every master rate with both clock idle levels
		for (int m = 0; m < 4; m++)
			for (int p = 0; p < 2; p++)
				masterXfer(4'(m), 1'(p), 8'h02, 0);
		masterXfer(spi_port_pkg::MODE_DIV16, 1'b0, 8'h02, 1);
		masterXfer(spi_port_pkg::MODE_DIV4, 1'b1, 8'h02, 2);
		masterXfer(spi_port_pkg::MODE_DIV4, 1'b0, 8'h06, 0);
		// Plain slave ignores the select pin
		regWrite(spi_port_pkg::ADDR_CONTROL, 8'h25);
		#1;
		`CHECK(sdoOe_n, 1'b0)
		// Slave with select: float, abort mid-byte, full byte asleep
		regWrite(spi_port_pkg::ADDR_STATUS, 8'h40);
		regWrite(spi_port_pkg::ADDR_FLAGS, 8'h02);
		regWrite(spi_port_pkg::ADDR_CONTROL, 8'h24);
		#1;
		`CHECK(sdoOe_n, 1'b1)
		`CHECK(sckOe_n, 1'b1)
		regWrite(spi_port_pkg::ADDR_BUFFER, $random(seed));
		far.driveByte(8'h00, 4, 3);
		#1;
		`CHECK(sdoOe_n, 1'b1)
		tx = $random(seed);
		rx = $random(seed);
		regWrite(spi_port_pkg::ADDR_BUFFER, tx);
		sleepMode <= 1'b1;
		far.driveByte(rx, 4, 8);
		#1;
		`CHECK(sdoOe_n, 1'b0)
		waitIrq(20);
		`CHECK(wakeReq, 1'b1)
		`CHECK(far.rxByte, tx)
		sleepMode <= 1'b0;
		regRead(spi_port_pkg::ADDR_BUFFER, rx);
		// Device reset in mid-byte aborts the transfer
		regWrite(spi_port_pkg::ADDR_CONTROL, 8'h22);
		regWrite(spi_port_pkg::ADDR_BUFFER, 8'h3c);
		repeat (50) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHECK(sckOe_n, 1'b1)
		`CHECK(sdoOe_n, 1'b1)
		regRead(spi_port_pkg::ADDR_CONTROL, 8'h00);
		repeat (600) @(posedge clk);
		#1;
		`CHECK(irqReq, 1'b0)
		tally_and_finish();
	end
endmodule
